/* File: common/orx_pkg.sv */
// constants, field layout and types for the per-channel range extension registers
// assumes one register clock; companion range codes arrive from logic on that clock
package orx_pkg;

  localparam int ORX_CH       = 8;
  localparam int ORX_CODE_W   = 2;
  localparam int ORX_CH_PER_RR = 4;
  localparam int ORX_RR_W     = ORX_CODE_W * ORX_CH_PER_RR;

  // register word layout
  localparam int ORX_DIR_BIT  = 15;
  localparam int ORX_ADDR_HI  = 14;
  localparam int ORX_ADDR_LO  = 9;
  localparam int ORX_RSVD_BIT = 8;
  localparam int ORX_EXT_HI   = 7;
  localparam int ORX_IDX_W    = ORX_ADDR_HI - ORX_ADDR_LO + 1;

  // register indices; byte address is four times the index
  localparam logic [ORX_IDX_W-1:0] ORX_IDX_SIDE_A = 6'h0a;
  localparam logic [ORX_IDX_W-1:0] ORX_IDX_SIDE_B = 6'h0b;
  localparam logic [ORX_IDX_W-1:0] ORX_IDX_CMD    = 6'h30;
  localparam logic [ORX_IDX_W-1:0] ORX_IDX_RDBK   = 6'h31;
  localparam int                   ORX_IDX_LSB    = 2;

  localparam logic [15:0] ORX_RST_SIDE_A = 16'h1400;
  localparam logic [15:0] ORX_RST_SIDE_B = 16'h1600;
  localparam logic [15:0] ORX_RST_RDBK   = 16'h0000;

  localparam logic [1:0] ORX_HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [1:0] ORX_HRESP_OKAY        = 2'h0;

  typedef enum logic [1:0] {
    ORX_PM10V,
    ORX_PM2V5,
    ORX_PM5V
  } orx_range_t;

  typedef struct packed {
    orx_range_t base;
    logic       widened;
  } orx_chan_range_t;

  function automatic orx_range_t orx_decode(input logic [ORX_CODE_W-1:0] code);
    orx_range_t r;
    r = ORX_PM10V;
    unique case (code)
      2'h0: r = ORX_PM10V;
      2'h1: r = ORX_PM2V5;
      2'h2: r = ORX_PM5V;
      2'h3: r = ORX_PM10V;
    endcase
    return r;
  endfunction

endpackage

/* File: rtl/orx_side_ext.sv */
// extension enable byte and effective per-channel range of one converter side
// assumes range codes come from the same clock domain, no synchroniser needed
`timescale 1ns/1ps
module orx_side_ext
  import orx_pkg::*;
#(
  parameter int                CH      = ORX_CH,
  parameter logic [ORX_CH-1:0] RST_EXT = '0
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    wr_en_in,
  input  wire logic [CH-1:0]           wr_byte_in,
  input  wire logic [ORX_RR_W-1:0]     range_lo_in,
  input  wire logic [ORX_RR_W-1:0]     range_hi_in,
  output logic      [CH-1:0]           ext_out,
  output orx_chan_range_t [CH-1:0]     chan_out
);

  logic [CH-1:0]           ext_q;
  orx_chan_range_t [CH-1:0] chan_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ext_q <= RST_EXT;
    end else if (wr_en_in) begin
      ext_q <= wr_byte_in;
    end
  end

  // low four channels read the low range register, upper four the high one
  for (genvar n = 0; n < CH; n++) begin : g_chan
    localparam int K = n % ORX_CH_PER_RR;
    logic [ORX_CODE_W-1:0] code;
    assign code = (n < ORX_CH_PER_RR) ? range_lo_in[K*ORX_CODE_W +: ORX_CODE_W]
                                      : range_hi_in[K*ORX_CODE_W +: ORX_CODE_W];
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        chan_q[n] <= '{base: ORX_PM10V, widened: 1'b0};
      end else begin
        chan_q[n].base    <= orx_decode(code);
        chan_q[n].widened <= ext_q[n];
      end
    end
  end

  assign ext_out  = ext_q;
  assign chan_out = chan_q;

endmodule // orx_side_ext

/* File: rtl/orx_ext_regs.sv */
// AHB-Lite slave holding the side A and side B range extension registers
// assumes a single AHB-Lite master, word transfers only, hsel from an outside decoder
// Functional notes
// - bit 15 of a register word: 0 reads the addressed register, 1 writes it
// - bits 14..9 address the register; side A is 0x0a, side B is 0x0b
// - bit 8 is reserved and always reads back as zero
// - extension bit n set widens channel n range by twenty percent, clear keeps it
// - side A channels 4..7 qualify register 0x05 codes, 0..3 register 0x04
// - side B channels 4..7 qualify register 0x07 codes, 0..3 register 0x06
// - side B register at 0xb resets to 0x1600, all extension bits clear
// - side A register at 0xa resets to 0x1400, all extension bits clear
// - range code 00 and 11 give 10 V, 01 gives 2.5 V, 10 gives 5 V
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module orx_ext_regs
  import orx_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 hsel_in,
  input  wire logic [ADDR_W-1:0]    haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic      [31:0]          hrdata_out,
  output logic                      hreadyout_out,
  output logic      [1:0]           hresp_out,
  input  wire logic [ORX_RR_W-1:0]  side_a_range_lo_in,
  input  wire logic [ORX_RR_W-1:0]  side_a_range_hi_in,
  input  wire logic [ORX_RR_W-1:0]  side_b_range_lo_in,
  input  wire logic [ORX_RR_W-1:0]  side_b_range_hi_in,
  output orx_chan_range_t [ORX_CH-1:0] side_a_range_out,
  output orx_chan_range_t [ORX_CH-1:0] side_b_range_out
);

  typedef enum logic [1:0] {
    ORX_BUS_IDLE,
    ORX_BUS_WRITE,
    ORX_BUS_READ,
    ORX_BUS_RDOUT
  } orx_bus_t;

  orx_bus_t             bus_q;
  orx_bus_t             bus_d;
  logic [ORX_IDX_W-1:0] idx_q;
  logic [31:0]          hrdata_q;
  logic [15:0]          rdbk_q;
  logic [ORX_CH-1:0]    ext_a;
  logic [ORX_CH-1:0]    ext_b;
  logic                 accept;
  logic                 cmd_wr;
  logic [15:0]          cmd_word;
  logic [ORX_IDX_W-1:0] cmd_idx;
  logic                 wr_a;
  logic                 wr_b;
  logic [ORX_CH-1:0]    wr_byte;

  // device register word as the host sees it: direction bit reads 0
  function automatic logic [15:0] dev_word(input logic [ORX_IDX_W-1:0] idx,
                                           input logic [ORX_CH-1:0] ea,
                                           input logic [ORX_CH-1:0] eb);
    logic [15:0] w;
    w = '0;
    if (idx == ORX_IDX_SIDE_A) begin
      w = {ORX_RST_SIDE_A[15:ORX_EXT_HI+1], ea};
    end else if (idx == ORX_IDX_SIDE_B) begin
      w = {ORX_RST_SIDE_B[15:ORX_EXT_HI+1], eb};
    end
    w[ORX_RSVD_BIT] = 1'b0;
    w[ORX_DIR_BIT]  = 1'b0;
    return w;
  endfunction

  function automatic logic [31:0] bus_word(input logic [ORX_IDX_W-1:0] idx,
                                           input logic [ORX_CH-1:0] ea,
                                           input logic [ORX_CH-1:0] eb,
                                           input logic [15:0] rb);
    logic [31:0] w;
    w = '0;
    if (idx == ORX_IDX_RDBK) begin
      w[15:0] = rb;
    end else begin
      w[15:0] = dev_word(idx, ea, eb);
    end
    return w;
  endfunction

  assign accept = hsel_in && hready_in && (htrans_in & ORX_HTRANS_NONSEQ_BIT) != 2'h0;

  // reads take one wait state so that hrdata comes from a flop and still sees
  // a write committed in the cycle just before
  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      ORX_BUS_READ: bus_d = ORX_BUS_RDOUT;
      ORX_BUS_IDLE, ORX_BUS_WRITE, ORX_BUS_RDOUT: begin
        if (accept) begin
          bus_d = hwrite_in ? ORX_BUS_WRITE : ORX_BUS_READ;
        end else begin
          bus_d = ORX_BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus_q <= ORX_BUS_IDLE;
      idx_q <= '0;
    end else begin
      bus_q <= bus_d;
      if (accept) begin
        idx_q <= haddr_in[ORX_IDX_LSB +: ORX_IDX_W];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hrdata_q <= '0;
    end else if (bus_q == ORX_BUS_READ) begin
      hrdata_q <= bus_word(idx_q, ext_a, ext_b, rdbk_q);
    end
  end

  // command word path: direction bit and address field pick the target
  assign cmd_word = hwdata_in[15:0];
  assign cmd_idx  = cmd_word[ORX_ADDR_HI:ORX_ADDR_LO];
  assign cmd_wr   = (bus_q == ORX_BUS_WRITE) && (idx_q == ORX_IDX_CMD);

  always_comb begin
    wr_a    = 1'b0;
    wr_b    = 1'b0;
    wr_byte = hwdata_in[ORX_EXT_HI:0]; // bit 8 never stored
    if (bus_q == ORX_BUS_WRITE) begin
      if (idx_q == ORX_IDX_SIDE_A) begin
        wr_a = 1'b1;
      end else if (idx_q == ORX_IDX_SIDE_B) begin
        wr_b = 1'b1;
      end else if (cmd_wr && cmd_word[ORX_DIR_BIT]) begin
        wr_a = (cmd_idx == ORX_IDX_SIDE_A);
        wr_b = (cmd_idx == ORX_IDX_SIDE_B);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdbk_q <= ORX_RST_RDBK;
    end else if (cmd_wr && !cmd_word[ORX_DIR_BIT]) begin
      rdbk_q <= dev_word(cmd_idx, ext_a, ext_b);
    end
  end

  orx_side_ext #(
    .CH      (ORX_CH),
    .RST_EXT (ORX_RST_SIDE_A[ORX_EXT_HI:0])
  ) u_side_a (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (wr_a),
    .wr_byte_in  (wr_byte),
    .range_lo_in (side_a_range_lo_in),
    .range_hi_in (side_a_range_hi_in),
    .ext_out     (ext_a),
    .chan_out    (side_a_range_out)
  );

  orx_side_ext #(
    .CH      (ORX_CH),
    .RST_EXT (ORX_RST_SIDE_B[ORX_EXT_HI:0])
  ) u_side_b (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (wr_b),
    .wr_byte_in  (wr_byte),
    .range_lo_in (side_b_range_lo_in),
    .range_hi_in (side_b_range_hi_in),
    .ext_out     (ext_b),
    .chan_out    (side_b_range_out)
  );

  assign hrdata_out    = hrdata_q;
  assign hreadyout_out = (bus_q != ORX_BUS_READ);
  assign hresp_out     = ORX_HRESP_OKAY;

  a_reset_side_a: assert property (@(posedge ref_clk_in)
    rst_in |=> ext_a == ORX_RST_SIDE_A[ORX_EXT_HI:0])
    else $error("side A extension bits not cleared by reset");

  // no write can commit while a read waits, so ext_b still equals what was loaded
  a_reset_side_b: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    bus_q == ORX_BUS_RDOUT && idx_q == ORX_IDX_SIDE_B |->
    hrdata_out[15:0] == {ORX_RST_SIDE_B[15:ORX_EXT_HI+1], ext_b})
    else $error("side B word does not match its reset layout");

  a_rsvd_reads_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    bus_q == ORX_BUS_RDOUT && (idx_q == ORX_IDX_SIDE_A || idx_q == ORX_IDX_SIDE_B ||
    idx_q == ORX_IDX_RDBK) |-> !hrdata_out[ORX_RSVD_BIT])
    else $error("reserved bit read back as one");

  a_direct_write_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    bus_q == ORX_BUS_WRITE && idx_q == ORX_IDX_SIDE_A |=>
    ext_a == $past(hwdata_in[ORX_EXT_HI:0]) ##1
    side_a_range_out[0].widened == $past(ext_a[0]))
    else $error("side A write not applied to channel widening");

  a_cmd_write_b: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cmd_wr && cmd_word[ORX_DIR_BIT] && cmd_idx == ORX_IDX_SIDE_B |=>
    ext_b == $past(hwdata_in[ORX_EXT_HI:0]) && $stable(ext_a))
    else $error("command write did not reach side B only");

  a_cmd_read_keeps: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cmd_wr && !cmd_word[ORX_DIR_BIT] |=> $stable(ext_a) && $stable(ext_b) &&
    rdbk_q[ORX_ADDR_HI:ORX_ADDR_LO] == (($past(cmd_idx) == ORX_IDX_SIDE_A ||
    $past(cmd_idx) == ORX_IDX_SIDE_B) ? $past(cmd_idx) : 6'h00))
    else $error("command read changed a register or lost its address");

  a_read_wait_state: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read data phase not exactly one wait state");

  a_hi_code_side_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |->
    side_a_range_out[4].base == orx_decode($past(side_a_range_hi_in[1:0])) &&
    side_a_range_out[0].base == orx_decode($past(side_a_range_lo_in[1:0])))
    else $error("side A channel not tied to its range register");

  a_lo_code_side_b: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |->
    side_b_range_out[3].base == orx_decode($past(side_b_range_lo_in[7:6])) &&
    side_b_range_out[7].base == orx_decode($past(side_b_range_hi_in[7:6])))
    else $error("side B channel not tied to its range register");

  a_code_decode: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(side_a_range_lo_in[3:2]) == 2'h3 |->
    side_a_range_out[1].base == ORX_PM10V)
    else $error("range code 11 did not decode to 10 V");

endmodule // orx_ext_regs

/* File: tb/tb_top.sv */
// self-checking bench for the range extension register block
// assumes the bench is the only AHB-Lite master and drives the range code inputs
`timescale 1ns/1ps
module tb_top;
  import orx_pkg::*;
  logic                         ref_clk_in = 1'b0;
  logic                         rst_in     = 1'b1;
  logic                         hsel_in    = 1'b1;
  logic [7:0]                   haddr_in   = '0;
  logic [1:0]                   htrans_in  = '0;
  logic                         hwrite_in  = 1'b0;
  logic [31:0]                  hwdata_in  = '0;
  logic [31:0]                  hrdata_out;
  logic                         hreadyout_out;
  logic [1:0]                   hresp_out;
  logic [ORX_RR_W-1:0]          ra_lo = '0, ra_hi = '0, rb_lo = '0, rb_hi = '0;
  orx_chan_range_t [ORX_CH-1:0] side_a_range_out, side_b_range_out;
  logic [7:0]                   ext_a, ext_b;
  logic [31:0]                  rd;
  int                           error_cnt  = 0;
  int                           n_compared = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  orx_ext_regs #(.ADDR_W(8)) i_orx_ext_regs (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .side_a_range_lo_in(ra_lo), .side_a_range_hi_in(ra_hi),
    .side_b_range_lo_in(rb_lo), .side_b_range_hi_in(rb_hi),
    .side_a_range_out(side_a_range_out), .side_b_range_out(side_b_range_out));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // entered just after a rising edge, leaves just after the edge that ends the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans_in <= ORX_HTRANS_NONSEQ_BIT;
    haddr_in  <= a;
    hwrite_in <= wr;
    do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
    check({30'h0, hresp_out}, {30'h0, ORX_HRESP_OKAY}, "hresp");
  endtask

  function automatic logic [31:0] exp_word(input logic [5:0] idx, input logic [7:0] e);
    return {16'h0, 1'b0, idx, 1'b0, e};
  endfunction

  function automatic orx_range_t exp_base(input logic [1:0] c);
    return (c == 2'h1) ? ORX_PM2V5 : (c == 2'h2) ? ORX_PM5V : ORX_PM10V;
  endfunction

  task automatic check_ranges();
    logic [1:0] ca, cb;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    for (int n = 0; n < ORX_CH; n++) begin
      ca = (n < 4) ? ra_lo[2*n +: 2] : ra_hi[2*(n-4) +: 2];
      cb = (n < 4) ? rb_lo[2*n +: 2] : rb_hi[2*(n-4) +: 2];
      check({29'h0, side_a_range_out[n]}, {29'h0, exp_base(ca), ext_a[n]}, "range a");
      check({29'h0, side_b_range_out[n]}, {29'h0, exp_base(cb), ext_b[n]}, "range b");
    end
    @(posedge ref_clk_in);
  endtask

  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    ext_a = '0;
    ext_b = '0;
    ahb(1'b0, 8'h28, '0);
    check(rd, 32'(ORX_RST_SIDE_A), "reset a");
    ahb(1'b0, 8'h2c, '0);
    check(rd, 32'(ORX_RST_SIDE_B), "reset b");
    check_ranges();
    $display("test reset done");
  endtask

  task automatic wr_side(input logic b, input logic [31:0] w);
    ahb(1'b1, b ? 8'h2c : 8'h28, w);
    if (b) ext_b = w[7:0];
    else ext_a = w[7:0];
  endtask

  initial begin
    logic [31:0] w;
    logic [5:0]  tgt;
    logic        b;
    void'($urandom(32'h747f0e71));
    do_reset();
    // unmapped and read-only places
    ahb(1'b1, 8'h80, $urandom);
    ahb(1'b0, 8'h80, '0);
    check(rd, 32'h0, "unmapped");
    ahb(1'b1, 8'hc4, $urandom);
    ahb(1'b0, 8'hc4, '0);
    check(rd, 32'(ORX_RST_RDBK), "readback ro");
    $display("test unmapped done");
    // direct writes with reserved bit set, read back at once
    for (int i = 0; i < 24; i++) begin
      b = 1'($urandom);
      w = $urandom | 32'h100;
      if (i < 2) w[7:0] = i ? 8'hff : 8'h00;
      wr_side(b, w);
      ahb(1'b0, b ? 8'h2c : 8'h28, '0);
      check(rd, exp_word(b ? ORX_IDX_SIDE_B : ORX_IDX_SIDE_A, b ? ext_b : ext_a), "direct");
    end
    check_ranges();
    $display("test direct done");
    // command port: both directions, both sides and a foreign target
    for (int i = 0; i < 24; i++) begin
      tgt = (i % 3 == 0) ? ORX_IDX_SIDE_A : (i % 3 == 1) ? ORX_IDX_SIDE_B : 6'h05;
      w = {$urandom} & 32'h0000_01ff;
      w[15] = i[0];
      w[14:9] = tgt;
      ahb(1'b1, 8'hc0, w);
      if (w[15] && tgt == ORX_IDX_SIDE_A) ext_a = w[7:0];
      if (w[15] && tgt == ORX_IDX_SIDE_B) ext_b = w[7:0];
      ahb(1'b0, 8'hc4, '0);
      if (!w[15])
        check(rd, (tgt == 6'h05) ? 32'h0 : exp_word(tgt, tgt[0] ? ext_b : ext_a), "cmd rd");
      ahb(1'b0, 8'h28, '0);
      check(rd, exp_word(ORX_IDX_SIDE_A, ext_a), "cmd a");
      ahb(1'b0, 8'h2c, '0);
      check(rd, exp_word(ORX_IDX_SIDE_B, ext_b), "cmd b");
    end
    ahb(1'b0, 8'hc0, '0);
    check(rd, 32'h0, "cmd port read");
    $display("test command done");
    // range codes: each code once in every group of four channels, then random
    for (int i = 0; i < 12; i++) begin
      ra_lo <= (i == 0) ? 8'he4 : 8'($urandom);
      ra_hi <= (i == 0) ? 8'h1b : 8'($urandom);
      rb_lo <= (i == 0) ? 8'h4e : 8'($urandom);
      rb_hi <= (i == 0) ? 8'hb1 : 8'($urandom);
      wr_side(i[0], $urandom);
      check_ranges();
    end
    $display("test ranges done");
    do_reset();
    conclude();
  end

  initial begin
    // the run needs about five hundred cycles; twenty thousand leaves wide margin
    #200000;
    error_cnt++;
    $display("Error at %0t: watchdog expired got %h expected %h", $time, 1'b1, 1'b0);
    conclude();
  end
endmodule // tb_top
